// ---- src/bmi_buf.sv ----
/*
 * Shared package for the block-move and instruction-format core, and the
 * two-entry skid buffer that carries decoded records to the consumer.
 * Assumes one clock, an asynchronous active-low reset, and same-clock neighbours.
 */
`timescale 1ns/100ps
package bmi_pkg;
   // First-word opcode classes; the layout of each class is set in the core decoder
   localparam logic [3:0] OPC_ONLY = 4'h0;
   localparam logic [3:0] OPC_BRANCH = 4'h4;
   localparam logic [3:0] OPC_REG_EXT = 4'h6;
   localparam logic [3:0] OPC_BLOCK_MOVE = 4'h7;
   // Field positions inside the first word
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 12;
   localparam int CC_LSB = 8;
   localparam int EXT_SIZE_LSB = 8;
   localparam int RN_LSB = 4;
   localparam int RM_LSB = 0;
   localparam int VARIANT_BIT = 0;
   // Extension size codes
   localparam logic [1:0] EXT_8 = 2'h0;
   localparam logic [1:0] EXT_16 = 2'h1;
   localparam logic [1:0] EXT_32 = 2'h2;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [31:0] PTR_RESET = 32'h0000_0000;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [1:0] {
      LAY_OP_ONLY,
      LAY_OP_REG,
      LAY_OP_REG_EXT,
      LAY_OP_CC_EXT
   } bmi_layout_t;

   typedef struct packed {
      bmi_layout_t layout;
      logic [3:0] opcode_field;
      logic [7:0] second_opcode_field;
      logic [1:0] reg_field_count;
      logic [3:0] first_reg_field;
      logic [3:0] second_reg_field;
      logic [2:0] first_addr_sel;
      logic [2:0] second_addr_sel;
      logic [1:0] ext_size;
      logic [31:0] operand_extension_field;
      logic [3:0] branch_condition_field;
      logic block_move;
      logic block_move_word_count;
   } bmi_dec_t;

   typedef struct packed {
      logic [15:0] count_word;
      logic [31:0] source_pointer;
      logic [31:0] dest_pointer;
   } bmi_regs_t;
endpackage

module bmi_buf import bmi_pkg::*; #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   typedef struct packed {
      logic [BUF_DEPTH-1:0][W-1:0] mem;
      logic [1:0] cnt;
   } bmi_buf_state_t;

   bmi_buf_state_t s_reg, s_next;
   logic push, pop;

   assign in_ready = (s_reg.cnt != 2'(BUF_DEPTH));
   assign out_valid = (s_reg.cnt != 2'h0);
   assign out_data = s_reg.mem[0];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_next = s_reg;
      // Shift register order keeps the head at slot 0
      if (pop) begin
         s_next.mem[0] = s_reg.mem[1];
      end
      if (push) begin
         if (s_reg.cnt == 2'h0 || (s_reg.cnt == 2'h1 && pop)) begin
            s_next.mem[0] = in_data;
         end else begin
            s_next.mem[1] = in_data;
         end
      end
      s_next.cnt = 2'(s_reg.cnt + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// ---- src/bmi_core.sv ----
/*
 * Instruction-format decoder with block byte move execution.
 * Assumes instruction words arrive from a same-clock fetch stream and the
 * data memory answers each request with a one-cycle ack on the same clock.
 */
`timescale 1ns/100ps
// Notes on behaviour
// - Move copies byte at source pointer to destination, both pointers step by one.
// - Byte variant counts low byte, word variant full count; zero count moves nothing.
// - Next instruction fetch starts the cycle right after the final byte write.
// - Instructions are taken as a sequence of 16-bit words.
// - Opcode always from top four bits; a second opcode field is supported.
// - Register fields: 3-bit address select, 3/4-bit data select, zero to two fields; the code gives 0 or 2 fields, never one.
// - Extension of 8, 16 or 32 bits follows the first word.
// - Branch instructions yield a condition field from the first word.
// - Four layouts: op only, op+regs, op+regs+ext, op+cond+ext.
module bmi_core import bmi_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Instruction word stream
   input wire logic insn_valid,
   output logic insn_ready,
   input wire logic [15:0] insn_word,
   // Register preload
   input wire logic regs_ld_valid,
   output logic regs_ld_ready,
   input wire bmi_regs_t regs_ld,
   // Register view
   output bmi_regs_t regs_view,
   output logic move_busy,
   // Decoded record stream
   output logic dec_valid,
   input wire logic dec_ready,
   output bmi_dec_t dec_out,
   // Data memory
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata
);
   typedef enum logic [2:0] {
      ST_FETCH,
      ST_EXT,
      ST_EMIT,
      ST_MV_RD,
      ST_MV_WR
   } bmi_st_t;

   typedef struct packed {
      bmi_st_t st;
      logic ext_left;
      bmi_dec_t dec;
      bmi_regs_t regs;
      logic [7:0] byte_hold;
   } bmi_state_t;

   bmi_state_t s_reg, s_next;
   logic buf_ready, push;
   logic [15:0] cnt_after;
   logic last_byte;

   assign insn_ready = (s_reg.st == ST_FETCH) || (s_reg.st == ST_EXT);
   assign regs_ld_ready = (s_reg.st == ST_FETCH);
   assign push = (s_reg.st == ST_EMIT);
   assign regs_view = s_reg.regs;
   assign move_busy = (s_reg.st == ST_MV_RD) || (s_reg.st == ST_MV_WR);
   assign mem_req = move_busy;
   assign mem_we = (s_reg.st == ST_MV_WR);
   assign mem_addr = mem_we ? s_reg.regs.dest_pointer : s_reg.regs.source_pointer;
   assign mem_wdata = s_reg.byte_hold;

   // Byte variant only touches the low byte of the count
   always_comb begin
      cnt_after = s_reg.regs.count_word;
      if (s_reg.dec.block_move_word_count) begin
         cnt_after = 16'(s_reg.regs.count_word - 16'h1);
      end else begin
         cnt_after[7:0] = 8'(s_reg.regs.count_word[7:0] - 8'h1);
      end
      last_byte = s_reg.dec.block_move_word_count ? (cnt_after == 16'h0) : (cnt_after[7:0] == 8'h0);
   end

   always_comb begin
      s_next = s_reg;
      unique case (s_reg.st)
         ST_FETCH: begin
            if (regs_ld_valid) begin
               s_next.regs = regs_ld;
            end
            if (insn_valid) begin
               s_next.dec = '0;
               s_next.dec.opcode_field = insn_word[OPC_MSB:OPC_LSB];
               s_next.dec.first_reg_field = insn_word[RN_LSB+3:RN_LSB];
               s_next.dec.second_reg_field = insn_word[RM_LSB+3:RM_LSB];
               s_next.dec.first_addr_sel = insn_word[RN_LSB+2:RN_LSB];
               s_next.dec.second_addr_sel = insn_word[RM_LSB+2:RM_LSB];
               s_next.st = ST_EMIT;
               unique case (insn_word[OPC_MSB:OPC_LSB])
                  OPC_ONLY: begin
                     s_next.dec.layout = LAY_OP_ONLY;
                     s_next.dec.second_opcode_field = insn_word[7:0];
                     s_next.dec.first_reg_field = 4'h0;
                     s_next.dec.second_reg_field = 4'h0;
                     s_next.dec.first_addr_sel = 3'h0;
                     s_next.dec.second_addr_sel = 3'h0;
                  end
                  OPC_BRANCH: begin
                     s_next.dec.layout = LAY_OP_CC_EXT;
                     s_next.dec.branch_condition_field = insn_word[CC_LSB+3:CC_LSB];
                     s_next.dec.ext_size = EXT_16;
                     s_next.dec.first_reg_field = 4'h0;
                     s_next.dec.second_reg_field = 4'h0;
                     s_next.dec.first_addr_sel = 3'h0;
                     s_next.dec.second_addr_sel = 3'h0;
                     s_next.st = ST_EXT;
                  end
                  OPC_REG_EXT: begin
                     s_next.dec.layout = LAY_OP_REG_EXT;
                     s_next.dec.reg_field_count = 2'h2;
                     s_next.dec.ext_size = insn_word[EXT_SIZE_LSB+1:EXT_SIZE_LSB];
                     s_next.dec.second_opcode_field = {6'h0, insn_word[11:10]};
                     s_next.ext_left = (insn_word[EXT_SIZE_LSB+1:EXT_SIZE_LSB] == EXT_32);
                     s_next.st = ST_EXT;
                  end
                  OPC_BLOCK_MOVE: begin
                     s_next.dec.layout = LAY_OP_ONLY;
                     s_next.dec.block_move = 1'b1;
                     s_next.dec.second_opcode_field = insn_word[11:4];
                     s_next.dec.block_move_word_count = insn_word[VARIANT_BIT];
                     s_next.dec.first_reg_field = 4'h0;
                     s_next.dec.second_reg_field = 4'h0;
                     s_next.dec.first_addr_sel = 3'h0;
                     s_next.dec.second_addr_sel = 3'h0;
                  end
                  default: begin
                     s_next.dec.layout = LAY_OP_REG;
                     s_next.dec.reg_field_count = 2'h2;
                     s_next.dec.second_opcode_field = insn_word[11:4];
                  end
               endcase
            end
         end
         ST_EXT: begin
            if (insn_valid) begin
               // 32-bit extensions arrive high word first
               if (s_reg.dec.ext_size == EXT_8) begin
                  s_next.dec.operand_extension_field = {24'h0, insn_word[7:0]};
               end else begin
                  s_next.dec.operand_extension_field = {s_reg.dec.operand_extension_field[15:0], insn_word};
               end
               s_next.ext_left = 1'b0;
               if (!s_reg.ext_left) begin
                  s_next.st = ST_EMIT;
               end
            end
         end
         ST_EMIT: begin
            // Stall here until the buffer has room; no record is dropped
            if (buf_ready) begin
               s_next.st = ST_FETCH;
               if (s_reg.dec.block_move) begin
                  if (s_reg.dec.block_move_word_count ? (s_reg.regs.count_word != 16'h0)
                      : (s_reg.regs.count_word[7:0] != 8'h0)) begin
                     s_next.st = ST_MV_RD;
                  end
               end
            end
         end
         ST_MV_RD: begin
            if (mem_ack) begin
               s_next.byte_hold = mem_rdata;
               s_next.st = ST_MV_WR;
            end
         end
         ST_MV_WR: begin
            if (mem_ack) begin
               s_next.regs.source_pointer = s_reg.regs.source_pointer + 32'h1;
               s_next.regs.dest_pointer = s_reg.regs.dest_pointer + 32'h1;
               s_next.regs.count_word = cnt_after;
               s_next.st = last_byte ? ST_FETCH : ST_MV_RD;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '{st: ST_FETCH, ext_left: 1'b0, dec: '0,
                    regs: '{CNT_RESET, PTR_RESET, PTR_RESET}, byte_hold: 8'h0};
      end else begin
         s_reg <= s_next;
      end
   end

   bmi_buf #(
      .W($bits(bmi_dec_t))
   ) u_buf (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(push),
      .in_ready(buf_ready),
      .in_data(s_reg.dec),
      .out_valid(dec_valid),
      .out_ready(dec_ready),
      .out_data(dec_out)
   );

   // Checks
   logic wr_done;
   logic fetch_take;
   assign wr_done = (s_reg.st == ST_MV_WR) && mem_ack;
   assign fetch_take = (s_reg.st == ST_FETCH) && insn_valid;

   property p_ptr_step;
      @(posedge clk) disable iff (!rst_b)
      wr_done |=> (regs_view.source_pointer == $past(regs_view.source_pointer) + 32'h1)
                  && (regs_view.dest_pointer == $past(regs_view.dest_pointer) + 32'h1);
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointers did not step by one");

   property p_rd_then_wr;
      @(posedge clk) disable iff (!rst_b)
      ((s_reg.st == ST_MV_RD) && mem_ack) |=> mem_we && (mem_wdata == $past(mem_rdata))
                                            && (mem_addr == regs_view.dest_pointer);
   endproperty
   a_rd_then_wr: assert property (p_rd_then_wr) else $error("read byte not written to destination");

   property p_byte_count;
      @(posedge clk) disable iff (!rst_b)
      (wr_done && !s_reg.dec.block_move_word_count) |=>
         (regs_view.count_word[7:0] == 8'($past(regs_view.count_word[7:0]) - 8'h1))
         && (regs_view.count_word[15:8] == $past(regs_view.count_word[15:8]));
   endproperty
   a_byte_count: assert property (p_byte_count) else $error("byte count step wrong");

   property p_zero_count;
      @(posedge clk) disable iff (!rst_b)
      ((s_reg.st == ST_EMIT) && buf_ready && s_reg.dec.block_move
       && (s_reg.dec.block_move_word_count ? regs_view.count_word == 16'h0 : regs_view.count_word[7:0] == 8'h0))
      |=> !mem_req [*2];
   endproperty
   a_zero_count: assert property (p_zero_count) else $error("zero count started a transfer");

   property p_next_fetch;
      @(posedge clk) disable iff (!rst_b)
      (wr_done && last_byte) |=> insn_ready && !mem_req;
   endproperty
   a_next_fetch: assert property (p_next_fetch) else $error("fetch not resumed after last byte");

   property p_end_state;
      @(posedge clk) disable iff (!rst_b)
      (wr_done && last_byte) |=> (s_reg.dec.block_move_word_count ? regs_view.count_word == 16'h0
                                  : regs_view.count_word[7:0] == 8'h0);
   endproperty
   a_end_state: assert property (p_end_state) else $error("count not zero after move");

   property p_opcode;
      @(posedge clk) disable iff (!rst_b)
      fetch_take |=> (s_reg.dec.opcode_field == $past(insn_word[15:12]));
   endproperty
   a_opcode: assert property (p_opcode) else $error("opcode field not from top bits");

   property p_regs;
      @(posedge clk) disable iff (!rst_b)
      (fetch_take && insn_word[15:12] == 4'h1) |=> (s_reg.dec.first_reg_field == $past(insn_word[7:4]))
         && (s_reg.dec.first_addr_sel == $past(insn_word[6:4])) && (s_reg.dec.reg_field_count == 2'h2);
   endproperty
   a_regs: assert property (p_regs) else $error("register fields wrong");

   property p_cond;
      @(posedge clk) disable iff (!rst_b)
      (fetch_take && insn_word[15:12] == OPC_BRANCH) |=> (s_reg.dec.branch_condition_field == $past(insn_word[11:8]))
         && (s_reg.dec.layout == LAY_OP_CC_EXT) && (s_reg.st == ST_EXT);
   endproperty
   a_cond: assert property (p_cond) else $error("condition field wrong");

   // Back-to-back words only; a gap between the halves is legal but unchecked here
   sequence s_two_ext;
      (s_reg.st == ST_EXT && insn_valid && s_reg.ext_left) ##1 (s_reg.st == ST_EXT && insn_valid);
   endsequence
   property p_ext32;
      @(posedge clk) disable iff (!rst_b)
      s_two_ext |=> (s_reg.st == ST_EMIT)
                    && (s_reg.dec.operand_extension_field == {$past(insn_word, 2), $past(insn_word)});
   endproperty
   a_ext32: assert property (p_ext32) else $error("32-bit extension not assembled");

   property p_ext8;
      @(posedge clk) disable iff (!rst_b)
      (s_reg.st == ST_EXT && insn_valid && s_reg.dec.ext_size == EXT_8)
      |=> (s_reg.dec.operand_extension_field == {24'h0, $past(insn_word[7:0])});
   endproperty
   a_ext8: assert property (p_ext8) else $error("8-bit extension not zero-extended");

   property p_reg_ext;
      @(posedge clk) disable iff (!rst_b)
      (fetch_take && insn_word[15:12] == OPC_REG_EXT) |=> (s_reg.dec.layout == LAY_OP_REG_EXT)
         && (s_reg.st == ST_EXT) && (s_reg.dec.ext_size == $past(insn_word[9:8]))
         && (s_reg.dec.reg_field_count == 2'h2);
   endproperty
   a_reg_ext: assert property (p_reg_ext) else $error("register-extension layout wrong");

   property p_req_hold;
      @(posedge clk) disable iff (!rst_b)
      (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("memory request changed before ack");

   // A full buffer must hold the record, not drop it
   property p_emit_stall;
      @(posedge clk) disable iff (!rst_b)
      (s_reg.st == ST_EMIT && !buf_ready) |=> (s_reg.st == ST_EMIT) && !insn_ready;
   endproperty
   a_emit_stall: assert property (p_emit_stall) else $error("record left emit without room");
endmodule

// ---- sim/bmi_mem_model.sv ----
/*
 * Byte memory model facing the core's data port.
 * Assumes requests are held until ack and each ack ends one request.
 */
`timescale 1ns/100ps
module bmi_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Data port
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   int dly;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 8'h00;
      dly = -1;
      forever begin
         @(posedge clk);
         #1;
         mem_ack = 1'b0;
         // Idle bus never keeps the last byte
         mem_rdata = ~mem_rdata;
         if (rst_b && mem_req) begin
            // Prompt or slow answer, chosen per access
            if (dly < 0) dly = $urandom % 3;
            if (dly == 0) begin
               mem_ack = 1'b1;
               if (!mem_we) mem_rdata = mem_addr[7:0] ^ 8'h3c;
            end
            dly = dly - 1;
         end else begin
            dly = -1;
         end
      end
   end
endmodule

// ---- sim/block_move_and_insn_format_tb_top.sv ----
/*
 * Self-checking bench for the decoder and block move core.
 * Assumes the core and the memory model share clk and rst_b.
 */
`timescale 1ns/100ps
module block_move_and_insn_format_tb_top import bmi_pkg::*;;
   logic clk, rst_b, insn_valid, insn_ready, regs_ld_valid, regs_ld_ready, move_busy;
   logic dec_valid, dec_ready, mem_req, mem_we, mem_ack, hold_ready, last_ack;
   logic [15:0] insn_word;
   logic [31:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   bmi_regs_t regs_ld, regs_view;
   bmi_dec_t dec_out;
   int errors, compares;
   logic [45:0] rec_q[$];
   logic [40:0] mem_q[$];

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   bmi_core u_dut (.clk(clk), .rst_b(rst_b), .insn_valid(insn_valid), .insn_ready(insn_ready),
      .insn_word(insn_word), .regs_ld_valid(regs_ld_valid), .regs_ld_ready(regs_ld_ready),
      .regs_ld(regs_ld), .regs_view(regs_view), .move_busy(move_busy), .dec_valid(dec_valid),
      .dec_ready(dec_ready), .dec_out(dec_out), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   bmi_mem_model u_mem (.clk(clk), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   task automatic report_and_stop();
      $display("Counts: %0d compares, %0d errors", compares, errors);
      if (errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic timeout();
      errors++;
      $display("[ERR] wait limit expected handshake seen none");
      report_and_stop();
   endtask

   task automatic chk_val(input string what, input logic [79:0] exp, input logic [79:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Only the fields that the layout defines are compared
   task automatic chk_rec(input logic [45:0] exp, input bmi_dec_t d);
      logic [45:0] k;
      if (d.block_move === 1'b1) k = {2'h0, d.opcode_field, 32'h0, 6'h0, d.block_move_word_count, 1'b1};
      else case (d.layout)
         LAY_OP_ONLY: k = {d.layout, d.opcode_field, 32'h0, d.second_opcode_field};
         LAY_OP_CC_EXT: k = {d.layout, d.opcode_field, d.operand_extension_field, d.branch_condition_field, 4'h0};
         LAY_OP_REG_EXT: k = {d.layout, d.opcode_field, d.operand_extension_field, d.first_reg_field,
            d.second_reg_field};
         default: k = {d.layout, d.opcode_field, 32'h0, d.first_reg_field, d.second_reg_field};
      endcase
      chk_val("record", {34'h0, exp}, {34'h0, k});
   endtask

   task automatic chk_mem(input logic [40:0] exp, input logic [40:0] got);
      chk_val("mem_access", {39'h0, exp}, {39'h0, got});
   endtask

   task automatic tick(input int k);
      repeat (k) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic put_word(input logic [15:0] w);
      int n;
      insn_valid = 1'b1;
      insn_word = w;
      for (n = 0; n < 500 && insn_ready !== 1'b1; n++) tick(1);
      if (n == 500) timeout();
      tick(1);
   endtask

   task automatic send_insn(input logic [15:0] w, input logic [31:0] ext);
      logic [45:0] k;
      logic [3:0] op;
      op = w[15:12];
      case (op)
         OPC_ONLY: k = {LAY_OP_ONLY, op, 32'h0, w[7:0]};
         OPC_BRANCH: k = {LAY_OP_CC_EXT, op, 16'h0, ext[15:0], w[11:8], 4'h0};
         OPC_REG_EXT: k = {LAY_OP_REG_EXT, op, (w[9:8] == EXT_8) ? {24'h0, ext[7:0]} :
            (w[9:8] == EXT_16) ? {16'h0, ext[15:0]} : ext, w[7:4], w[3:0]};
         OPC_BLOCK_MOVE: k = {2'h0, op, 32'h0, 6'h0, w[0], 1'b1};
         default: k = {LAY_OP_REG, op, 32'h0, w[7:4], w[3:0]};
      endcase
      rec_q.push_back(k);
      put_word(w);
      if (op == OPC_REG_EXT && w[9:8] == EXT_32) put_word(ext[31:16]);
      if (op == OPC_BRANCH || op == OPC_REG_EXT) put_word(ext[15:0]);
   endtask

   task automatic drain();
      int n;
      for (n = 0; n < 3000 && rec_q.size() != 0; n++) tick(1);
      if (n == 3000) timeout();
   endtask

   task automatic run_move(input logic wv, input bmi_regs_t r);
      int n, cnt;
      bmi_regs_t e;
      cnt = wv ? r.count_word : r.count_word[7:0];
      for (n = 0; n < cnt; n++) begin
         mem_q.push_back({1'b0, r.source_pointer + n, 8'h00});
         mem_q.push_back({1'b1, r.dest_pointer + n, 8'(r.source_pointer + n) ^ 8'h3c});
      end
      e = '{wv ? 16'h0 : {r.count_word[15:8], 8'h00}, r.source_pointer + cnt, r.dest_pointer + cnt};
      regs_ld_valid = 1'b1;
      regs_ld = r;
      for (n = 0; n < 500 && regs_ld_ready !== 1'b1; n++) tick(1);
      if (n == 500) timeout();
      tick(1);
      regs_ld_valid = 1'b0;
      send_insn({OPC_BLOCK_MOVE, 11'h000, wv}, 32'h0);
      insn_valid = 1'b0;
      for (n = 0; n < 5000 && (mem_q.size() != 0 || move_busy !== 1'b0); n++) tick(1);
      if (n == 5000) timeout();
      tick(3);
      chk_val("regs_view", e, regs_view);
   endtask

   // Watchers: oldest note is compared whenever a result shows
   always @(posedge clk) begin
      if (last_ack) chk_val("ready_after_move", 80'h1, {79'h0, insn_ready});
      last_ack = 1'b0;
      if (rst_b && dec_valid === 1'b1 && dec_ready === 1'b1) begin
         if (rec_q.size() == 0) chk_val("extra_record", 80'h0, 80'h1);
         else chk_rec(rec_q.pop_front(), dec_out);
      end
      if (rst_b && mem_req === 1'b1 && mem_ack === 1'b1) begin
         if (mem_q.size() == 0) chk_val("extra_access", 80'h0, 80'h1);
         else begin
            chk_mem(mem_q.pop_front(), {mem_we, mem_addr, mem_we ? mem_wdata : 8'h00});
            if (mem_q.size() == 0) last_ack = 1'b1;
         end
      end
   end

   initial begin
      dec_ready = 1'b0;
      forever begin
         tick(1);
         dec_ready = hold_ready ? 1'b0 : (($urandom % 4) != 0);
      end
   end

   initial begin
      int i;
      logic [15:0] w;
      errors = 0;
      compares = 0;
      hold_ready = 1'b0;
      rst_b = 1'b0;
      insn_valid = 1'b0;
      insn_word = 16'h0000;
      regs_ld_valid = 1'b0;
      regs_ld = '0;
      void'($urandom(69461));
      tick(10);
      chk_val("reset_regs", 80'h0, regs_view);
      chk_val("reset_ctrl", 80'h1, {77'h0, dec_valid, mem_req, insn_ready});
      rst_b = 1'b1;
      send_insn(16'h0a5c, 32'h0);
      send_insn(16'h6c5a, 32'h0000_ab77);
      send_insn(16'h6d21, 32'h0000_beef);
      send_insn(16'h6e43, 32'h89ab_cdef);
      send_insn(16'h3fe1, 32'h0);
      for (i = 0; i < 16; i++) send_insn({OPC_BRANCH, 4'(i), 8'h00}, 32'(i * 16'h1111));
      for (i = 0; i < 20; i++) begin
         w = 16'($urandom);
         if (w[15:12] == OPC_BLOCK_MOVE) w[15:12] = 4'h1;
         if (w[15:12] == OPC_REG_EXT) w[9:8] = 2'($urandom % 3);
         send_insn(w, $urandom);
      end
      insn_valid = 1'b0;
      drain();
      $display("Test decode done");
      // Buffer full: third record must wait in emit
      hold_ready = 1'b1;
      tick(2);
      for (i = 0; i < 3; i++) send_insn(16'h1000 + 16'(i), 32'h0);
      insn_valid = 1'b0;
      tick(4);
      chk_val("full_stall", 80'h2, {78'h0, dec_valid, insn_ready});
      hold_ready = 1'b0;
      drain();
      $display("Test buffer done");
      run_move(1'b0, '{16'h5a04, 32'hffff_fffe, 32'h0000_1000});
      run_move(1'b1, '{16'h0103, 32'h0000_2000, 32'h0000_3000});
      run_move(1'b0, '{16'h1200, 32'h0000_4000, 32'h0000_5000});
      run_move(1'b1, '{16'h0000, 32'h0000_6000, 32'h0000_7000});
      for (i = 0; i < 2; i++) run_move(1'($urandom), '{16'(1 + $urandom % 6), $urandom, $urandom});
      drain();
      $display("Test move done");
      report_and_stop();
   end
endmodule
